//--- ebi_core.sv
// Purpose: External bus controller driving address, data, chip selects, strobes, latch strobe and bus clock.
// Assumes: Core requests arrive on i_core_clk; bus pins are resolved by the bench from enables.
// Notes: The bus clock is the core clock gated by its enable, so its falling edge is mid-cycle.
`timescale 1ns/1ps
`include "ebi_map.svh"
// Contract
// R1 - Bus pins active only in expansion modes
// R2 - Mux field picks separate or multiplexed bus
// R3 - 8-bit mux shares D0-7 with A0-7
// R4 - 16-bit mux shares D0-7 with A1-8
// R5 - 16-bit mux space reaches even addresses only
// R6 - Port selects give 12, 16, 20 address bits
// R7 - Software uses only three width combinations
// R8 - Address may be stale until external access
// R9 - Width pin high means eight data lines
// R10 - Width pin held constant while running
// R11 - Enable bit turns pin into chip select
// R12 - Four areas each own a chip select
// R13 - Area wait bit selects programmed wait count
// R14 - Strobe style bit picks strobe combination
// R15 - Split strobes select written byte lanes
// R16 - Byte select with A0 encodes lanes
// R17 - Latch strobe pulses on multiplexed accesses
// R18 - Whole-space mux frees upper address pins
// R19 - Sample wait input at last falling edge; code uses the two-flop synchronised pin, sampled on rising edges
// R20 - Hold all outputs during inserted wait
// R21 - Wait input high resumes the cycle
// R22 - Wait input honoured only with wait bit clear
// R23 - Mode field selects single, expansion, micro
// R24 - Wait code gives one to three waits; code inserts zero to three wait states for codes 0 to 3
// R25 - Bus clock output follows core clock
module ebi_core (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [`EBI_ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   input wire logic i_req_valid,
   input wire ebi_pkg::ebi_req_type i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_data,
   input wire logic i_bus8,
   input wire logic i_wait_n,
   input wire logic [15:0] i_data,
   output ebi_pkg::ebi_pins_type o_pins,
   output logic [19:0] o_addr_oe,
   output logic [3:0] o_cs_oe,
   output logic o_strobe_oe,
   output logic o_bclk,
   output logic o_bclk_oe
);
   logic [7:0] mode_a_q, mode_a_d;
   logic [7:0] mode_b_q, mode_b_d;
   logic [7:0] cs_ctrl_q, cs_ctrl_d;
   logic [7:0] wait_cnt_q, wait_cnt_d;
   logic [7:0] rdata_q, rdata_d;
   ebi_pkg::ebi_state_type st_q, st_d;
   ebi_pkg::ebi_req_type req_q, req_d;
   logic [1:0] wcnt_q, wcnt_d;
   logic mux_q, mux_d;
   logic ale_q, ale_d;
   logic [15:0] rsp_q, rsp_d;
   logic rsp_v_q, rsp_v_d;
   logic [19:0] addr_q, addr_d;
   logic bus8_s, wait_n_s;
   logic [15:0] data_s;
   logic ext_mode, mux_whole, nowait, strobe_on, rd_n, wrl_n, wrh_n;
   logic [1:0] mux_sel;
   ebi_pkg::ebi_pmode_type pmode;

   ebi_sync #(.WIDTH(18), .RST_VAL(18'h3ffff)) u_sync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_bus8, i_wait_n, i_data}),
      .o_sync({bus8_s, wait_n_s, data_s})
   );

   always_comb begin
      pmode = ebi_pkg::ebi_pmode_type'(mode_a_q[`EBI_B_PM_HI:`EBI_B_PM_LO]); // R23
      ext_mode = (pmode == ebi_pkg::EBI_PM_EXPAND) || (pmode == ebi_pkg::EBI_PM_MICRO); // R1
      mux_sel = mode_a_q[`EBI_B_MUX_HI:`EBI_B_MUX_LO];
      mux_whole = ext_mode && (mux_sel == 2'h3);
   end

   // Register port. The forbidden mode code is refused so the block never sits in an undefined mode.
   always_comb begin
      mode_a_d = mode_a_q;
      mode_b_d = mode_b_q;
      cs_ctrl_d = cs_ctrl_q;
      wait_cnt_d = wait_cnt_q;
      rdata_d = 8'h00;
      if (i_reg_wr) begin
         case (i_reg_addr)
            `EBI_OFF_MODE_A: begin
               if (i_reg_wdata[`EBI_B_PM_HI:`EBI_B_PM_LO] != 2'h2) begin
                  mode_a_d = i_reg_wdata; // R23
               end
            end
            `EBI_OFF_MODE_B: mode_b_d = i_reg_wdata & 8'h02;
            `EBI_OFF_CS_CTRL: cs_ctrl_d = i_reg_wdata;
            `EBI_OFF_WAIT_CNT: wait_cnt_d = i_reg_wdata;
            default: begin
            end
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            `EBI_OFF_MODE_A: rdata_d = mode_a_q;
            `EBI_OFF_MODE_B: rdata_d = mode_b_q;
            `EBI_OFF_CS_CTRL: rdata_d = cs_ctrl_q;
            `EBI_OFF_WAIT_CNT: rdata_d = wait_cnt_q;
            `EBI_OFF_STATUS: rdata_d = {1'b0, bus8_s, wait_n_s, st_q[5:1]};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Bus cycle sequencer.
   always_comb begin
      st_d = st_q;
      req_d = req_q;
      wcnt_d = wcnt_q;
      mux_d = mux_q;
      ale_d = 1'b0;
      rsp_d = rsp_q;
      rsp_v_d = 1'b0;
      addr_d = addr_q;
      nowait = cs_ctrl_q[`EBI_B_NOWAIT0 + req_q.area]; // R13
      o_req_ready = ext_mode && (st_q == ebi_pkg::EBI_ST_IDLE);
      case (st_q)
         ebi_pkg::EBI_ST_IDLE: begin
            if (o_req_valid_gate(i_req_valid, ext_mode)) begin
               req_d = i_req;
               mux_d = ext_mode && ((mux_sel == 2'h3) || (mux_sel == 2'h1 && i_req.area == 2'h2) ||
                       (mux_sel == 2'h2 && i_req.area == 2'h1)); // R2
               if (mux_d && !bus8_s) begin
                  req_d.addr = {i_req.addr[19:1], 1'b0}; // R5
                  req_d.word = 1'b0;
               end
               if (bus8_s) begin
                  req_d.word = 1'b0; // R9
               end
               addr_d = req_d.addr; // R8
               ale_d = mux_d; // R17
               wcnt_d = wait_cnt_q[2 * i_req.area +: 2]; // R24
               st_d = ebi_pkg::EBI_ST_ADDR;
            end
         end
         ebi_pkg::EBI_ST_ADDR: begin
            if (!nowait || mux_q) begin
               st_d = (wcnt_q == 2'h0) ? ebi_pkg::EBI_ST_LAST : ebi_pkg::EBI_ST_SWAIT; // R13
            end else begin
               st_d = ebi_pkg::EBI_ST_END;
            end
         end
         ebi_pkg::EBI_ST_SWAIT: begin
            wcnt_d = wcnt_q - 2'h1;
            if (wcnt_q == 2'h1) begin
               st_d = ebi_pkg::EBI_ST_LAST;
            end
         end
         ebi_pkg::EBI_ST_LAST, ebi_pkg::EBI_ST_RDY: begin
            // The synchronised pin stands for the value seen at the core clock rising edge two edges before the one that ends this cycle.
            if (!nowait && !wait_n_s) begin
               st_d = ebi_pkg::EBI_ST_RDY; // R19 R22
            end else begin
               st_d = ebi_pkg::EBI_ST_END; // R21
            end
         end
         ebi_pkg::EBI_ST_END: begin
            rsp_d = bus8_s ? {8'h00, data_s[7:0]} : data_s;
            rsp_v_d = 1'b1;
            st_d = ebi_pkg::EBI_ST_IDLE;
         end
         default: st_d = ebi_pkg::EBI_ST_IDLE;
      endcase
   end

   function automatic logic o_req_valid_gate(input logic v, input logic en);
      o_req_valid_gate = v & en;
   endfunction

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         mode_a_q <= `EBI_RST_MODE_A;
         mode_b_q <= `EBI_RST_MODE_B;
         cs_ctrl_q <= `EBI_RST_CS_CTRL;
         wait_cnt_q <= `EBI_RST_WAIT_CNT;
         rdata_q <= 8'h00;
         st_q <= ebi_pkg::EBI_ST_IDLE;
         req_q <= '0;
         wcnt_q <= 2'h0;
         mux_q <= 1'b0;
         ale_q <= 1'b0;
         rsp_q <= 16'h0000;
         rsp_v_q <= 1'b0;
         addr_q <= 20'h00000;
      end else begin
         mode_a_q <= mode_a_d;
         mode_b_q <= mode_b_d;
         cs_ctrl_q <= cs_ctrl_d;
         wait_cnt_q <= wait_cnt_d;
         rdata_q <= rdata_d;
         st_q <= st_d;
         req_q <= req_d;
         wcnt_q <= wcnt_d;
         mux_q <= mux_d;
         ale_q <= ale_d;
         rsp_q <= rsp_d;
         rsp_v_q <= rsp_v_d;
         addr_q <= addr_d;
      end
   end

   // Strobes go active after the address phase; RDY waits freeze every bus pin output except the bus clock, which keeps following the core clock.
   assign strobe_on = (st_q != ebi_pkg::EBI_ST_IDLE) && (st_q != ebi_pkg::EBI_ST_ADDR); // R20

   ebi_lanes u_lanes (
      .i_active(st_q != ebi_pkg::EBI_ST_IDLE),
      .i_strobe_on(strobe_on),
      .i_write(req_q.write),
      .i_word(req_q.word),
      .i_a0(req_q.addr[0]),
      .i_bus8(bus8_s),
      .i_split(mode_a_q[`EBI_B_STROBE]),
      .o_rd_n(rd_n),
      .o_wrl_n(wrl_n),
      .o_wrh_n(wrh_n)
   );

   always_comb begin
      o_pins.addr = addr_q;
      o_pins.data_o = 16'h0000;
      o_pins.data_oe = 16'h0000;
      o_pins.cs_n = 4'hf;
      o_pins.rd_n = rd_n;
      o_pins.wrl_n = wrl_n;
      o_pins.wrh_n = wrh_n;
      o_pins.ale = ale_q; // R17
      if (st_q != ebi_pkg::EBI_ST_IDLE) begin
         o_pins.cs_n[req_q.area] = 1'b0; // R12
         if (mux_q && !strobe_on) begin
            if (bus8_s) begin
               o_pins.addr[7:0] = addr_q[7:0]; // R3
            end
         end else if (mux_q) begin
            if (bus8_s) begin
               o_pins.addr[7:0] = req_q.wdata[7:0]; // R3
            end else begin
               o_pins.addr[8:1] = req_q.wdata[7:0]; // R4
            end
         end
         if (req_q.write && strobe_on && !mux_q) begin
            o_pins.data_o = req_q.wdata;
            o_pins.data_oe = bus8_s ? 16'h00ff : 16'hffff; // R9
         end
      end
      o_cs_oe = ext_mode ? cs_ctrl_q[3:0] : 4'h0; // R11
      o_addr_oe = 20'h00000;
      if (ext_mode) begin
         o_addr_oe = 20'h00fff; // R6
         if (!mode_b_q[`EBI_B_MID]) begin
            o_addr_oe[15:12] = 4'hf;
         end
         if (!mode_a_q[`EBI_B_UPPER]) begin
            o_addr_oe[19:16] = 4'hf;
         end
         if (mux_whole) begin
            o_addr_oe[19:9] = 11'h000; // R18
         end
      end
      o_strobe_oe = ext_mode;
      o_bclk_oe = ext_mode && !mode_a_q[`EBI_B_BCLK_DIS]; // R25
   end

   assign o_bclk = i_core_clk & o_bclk_oe; // R25
   assign o_reg_rdata = rdata_q;
   assign o_rsp_valid = rsp_v_q;
   assign o_rsp_data = rsp_q;
endmodule

//--- ebi_core_bench.sv
// Purpose: Self-checking bench for the external bus controller.
// Assumes: Width pin low for the first run, then high after a second reset; it never moves outside reset.
// Notes: Latencies count cycles from the taking edge to the response.
`timescale 1ns/1ps
`include "ebi_map.svh"
module ebi_core_bench;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, vld = 1'b0, split = 1'b1, mux = 1'b0, b8 = 1'b0;
   logic [7:0] ra = 8'h00, rw = 8'h00, q, rq, lat;
   ebi_pkg::ebi_req_type req = '0;
   ebi_pkg::ebi_pins_type pins;
   logic rdy, rv, bclk_oe, bclk, soe, wait_n, a0_s, ale_s;
   logic [15:0] rdat, din;
   logic [19:0] aoe, lat_a, oe_s;
   logic [3:0] coe, cs_s, stall = 4'h0;
   logic [2:0] st_s;
   logic [7:0] exp_lat [4] = '{8'h3, 8'h5, 8'h6, 8'h4};
   logic [19:0] bs_a [3] = '{20'h21, 20'h20, 20'h20};
   logic [3:0] bs_e [3] = '{4'h5, 4'h6, 4'h8};
   int n_mismatch = 0, n_checks = 0;
   ebi_core i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rq), .i_req_valid(vld), .i_req(req), .o_req_ready(rdy), .o_rsp_valid(rv),
      .o_rsp_data(rdat), .i_bus8(b8), .i_wait_n(wait_n), .i_data(din), .o_pins(pins), .o_addr_oe(aoe),
      .o_cs_oe(coe), .o_strobe_oe(soe), .o_bclk(bclk), .o_bclk_oe(bclk_oe));
   ebi_ext_mem i_mem (.i_core_clk(clk), .i_pins(pins), .i_split(split), .i_mux(mux), .i_stall(stall),
      .o_data(din), .o_wait_n(wait_n), .o_latched(lat_a));
   initial forever #5 clk = ~clk;
   task conclude;
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [19:0] s, input logic [19:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task rdr(input logic [7:0] a);
      @(posedge clk) rd <= 1'b1;
      ra <= a;
      @(posedge clk) rd <= 1'b0;
      #1 q = rq;
   endtask
   // Every write is read back at once, which also exercises back-to-back strobes.
   task wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) wr <= 1'b1;
      ra <= a;
      rw <= d;
      @(posedge clk) wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1 q = rq;
   endtask
   task bus(input logic [1:0] ar, input logic [19:0] a, input logic w, input logic wo, input logic [15:0] d);
      int n;
      @(posedge clk) vld <= 1'b1;
      req <= '{addr: a, wdata: d, area: ar, write: w, word: wo};
      #1 n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge clk) #1 n++;
      end
      if (rdy !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
      @(posedge clk) vld <= 1'b0;
      {cs_s, st_s, a0_s, ale_s, oe_s, lat} = {4'hf, 3'h7, 2'h0, 20'h0, 8'h0};
      while (lat < 8'd80) begin
         #1 lat++;
         if (pins.cs_n !== 4'hf) begin
            cs_s &= pins.cs_n;
            st_s &= {pins.rd_n, pins.wrl_n, pins.wrh_n};
            a0_s |= pins.addr[0];
            oe_s |= aoe;
         end
         ale_s |= pins.ale;
         if (rv === 1'b1) break;
         @(posedge clk);
      end
      if (lat == 8'd80) begin
         n_mismatch++;
         conclude();
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdr(`EBI_OFF_MODE_A); chk(q, `EBI_RST_MODE_A);
      rdr(`EBI_OFF_CS_CTRL); chk(q, 8'h01);
      rdr(`EBI_OFF_WAIT_CNT); chk(q, 8'h00);
      chk({rdy, soe, coe}, 6'h0);
      wrr(`EBI_OFF_MODE_A, 8'h02); chk(q, 8'h00);
      wrr(8'h3f, 8'hff); chk(q, 8'h00);
      wrr(`EBI_OFF_MODE_A, 8'h85); chk({q, bclk_oe, bclk}, 10'h214);
      wrr(`EBI_OFF_MODE_A, 8'h05); chk({rdy, soe, bclk_oe, bclk}, 4'hf);
      wrr(`EBI_OFF_CS_CTRL, 8'h1a); chk(coe, 4'ha);
      wrr(`EBI_OFF_CS_CTRL, 8'h1f); chk(coe, 4'hf);
      wrr(`EBI_OFF_WAIT_CNT, 8'h24); chk(q, 8'h24);
      for (int i = 0; i < 4; i++) begin
         bus(i[1:0], {13'h0, i[1:0], 5'h0}, 1'b1, 1'b1, 16'ha5c0 | {14'h0, i[1:0]});
         chk(lat, exp_lat[i]);
         chk({cs_s, st_s}, {~(4'h1 << i), 3'h4});
      end
      bus(2'h1, 20'h21, 1'b1, 1'b0, 16'h7e7e); chk(st_s, 3'h6);
      bus(2'h1, 20'h20, 1'b1, 1'b0, 16'h3c3c); chk(st_s, 3'h5);
      bus(2'h2, 20'h20, 1'b0, 1'b1, 16'h0); chk({st_s, rdat}, {3'h3, 16'h7e3c});
      stall = 4'h6;
      bus(2'h2, 20'h20, 1'b0, 1'b1, 16'h0); chk({lat > 8'h6, rdat}, {1'b1, 16'h7e3c});
      bus(2'h0, 20'h0, 1'b0, 1'b1, 16'h0); chk(lat, 8'h3);
      stall = 4'h0;
      split = 1'b0;
      wrr(`EBI_OFF_MODE_A, 8'h01);
      for (int i = 0; i < 3; i++) begin
         bus(2'h3, bs_a[i], i == 2, i == 2, 16'h0); chk({st_s, a0_s}, bs_e[i]);
      end
      chk(oe_s[19:16], 4'hf);
      wrr(`EBI_OFF_MODE_A, 8'h41);
      wrr(`EBI_OFF_MODE_B, 8'h02);
      bus(2'h3, 20'h0, 1'b0, 1'b1, 16'h0); chk(oe_s[19:12], 8'h0);
      wrr(`EBI_OFF_MODE_B, 8'h00);
      wrr(`EBI_OFF_MODE_A, 8'h11);
      mux = 1'b1;
      bus(2'h2, 20'h47, 1'b0, 1'b0, 16'h0); chk({ale_s, lat_a[8:0]}, {1'b1, 9'h046});
      bus(2'h1, 20'h20, 1'b0, 1'b1, 16'h0); chk(ale_s, 1'b0);
      // The width pin is only moved while reset holds the block.
      @(posedge clk);
      rst <= 1'b1;
      b8 <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdr(`EBI_OFF_MODE_A); chk({q, rdy, soe}, 10'h000);
      wrr(`EBI_OFF_MODE_A, 8'h35); chk(aoe, 20'h001ff);
      bus(2'h0, 20'h12345, 1'b1, 1'b1, 16'ha5c3); chk({ale_s, st_s, lat_a[7:0]}, 12'hd45);
      conclude();
   end
endmodule

//--- ebi_core_properties.sv
// Purpose: Port-level assertions for the external bus controller.
// Assumes: Bound to ebi_core; sees only its ports.
// Notes: Latency bounds follow the hand-over walk of a bus cycle.
`timescale 1ns/1ps
`include "ebi_map.svh"
module ebi_core_props (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [`EBI_ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_req_valid,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire ebi_pkg::ebi_pins_type o_pins,
   input wire logic o_strobe_oe
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_cs_wr;
      i_reg_wr && i_reg_addr == `EBI_OFF_CS_CTRL;
   endsequence
   sequence s_cs_rd;
      i_reg_rd && i_reg_addr == `EBI_OFF_CS_CTRL;
   endsequence
   a_cs_readback: assert property (s_cs_wr ##1 s_cs_rd |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("chip select control readback differs");
   a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_ready_ext: assert property (o_req_ready |-> o_strobe_oe)
      else $error("ready while bus pins are not driven");
   a_ale_busy: assert property (o_pins.ale |-> !o_req_ready)
      else $error("latch strobe outside a bus cycle");
   a_ale_pulse: assert property ($rose(o_pins.ale) |=> $fell(o_pins.ale))
      else $error("latch strobe longer than one cycle");
   a_strobe_excl: assert property (!o_pins.rd_n |-> o_pins.wrl_n)
      else $error("read and low write strobe together");
   a_cs_hold: assert property (o_pins.cs_n != 4'hf && $past(o_pins.cs_n) != 4'hf |-> $stable(o_pins.cs_n))
      else $error("chip select changed inside a cycle");
   a_wait_hold: assert property (!o_pins.rd_n && !$past(o_pins.rd_n) |-> $stable(o_pins.wrh_n) && $stable(o_pins.ale))
      else $error("strobes moved during a stretched read");
   a_rsp_bound: assert property (i_req_valid && o_req_ready |-> ##[3:60] o_rsp_valid)
      else $error("bus cycle did not complete in time");
   a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
      else $error("response longer than one cycle");
endmodule
bind ebi_core ebi_core_props i_props (.i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
   .o_reg_rdata, .i_req_valid, .o_req_ready, .o_rsp_valid, .o_pins, .o_strobe_oe);

//--- ebi_ext_mem.sv
// Purpose: Behavioural external memory on the parallel bus.
// Assumes: Stores only split-strobe writes; byte-select writes are observed, not stored.
// Notes: Released data lines show a changing pattern so a stale sample cannot pass.
`timescale 1ns/1ps
module ebi_ext_mem (
   input wire logic i_core_clk,
   input wire ebi_pkg::ebi_pins_type i_pins,
   input wire logic i_split,
   input wire logic i_mux,
   input wire logic [3:0] i_stall,
   output logic [15:0] o_data,
   output logic o_wait_n,
   output logic [19:0] o_latched
);
   logic [15:0] mem [0:255];
   logic [15:0] last = 16'h0;
   int cnt = 0;
   logic sel;
   logic [7:0] idx;
   assign sel = i_pins.cs_n != 4'hf;
   assign idx = i_mux ? o_latched[8:1] : i_pins.addr[8:1];
   // The address is taken at the clock edge that ends the latch strobe. The data overlay starts at that same edge,
   // so the value just before it is what a latch closing on the falling strobe holds.
   always @(posedge i_core_clk) begin
      if (i_pins.ale) o_latched <= i_pins.addr;
   end
   always @(posedge i_core_clk) begin
      last <= o_data;
      cnt <= sel ? cnt + 1 : 0;
      if (sel && i_split && !i_pins.wrl_n) mem[idx][7:0] <= i_pins.data_o[7:0];
      if (sel && i_split && !i_pins.wrh_n) mem[idx][15:8] <= i_pins.data_o[15:8];
   end
   assign o_data = (sel && !i_pins.rd_n) ? mem[idx] : ~last;
   // The pull-up keeps the line high whenever no stall is requested.
   assign o_wait_n = !(sel && cnt < int'(i_stall));
endmodule

//--- ebi_lanes.sv
// Purpose: Strobe and byte-lane encoding for one bus cycle.
// Assumes: Inputs are registered request fields; output is combinational.
// Notes: Active-low strobes; high means idle.
`timescale 1ns/1ps
module ebi_lanes (
   input wire logic i_active,
   input wire logic i_strobe_on,
   input wire logic i_write,
   input wire logic i_word,
   input wire logic i_a0,
   input wire logic i_bus8,
   input wire logic i_split,
   output logic o_rd_n,
   output logic o_wrl_n,
   output logic o_wrh_n
);
   logic split_eff;

   always_comb begin
      split_eff = i_split & ~i_bus8; // R14
      o_rd_n = 1'b1;
      o_wrl_n = 1'b1;
      o_wrh_n = 1'b1;
      if (i_active) begin
         o_wrh_n = ~(~i_bus8 & (i_word | i_a0)); // R16
         if (i_strobe_on) begin
            if (!i_write) begin
               o_rd_n = 1'b0; // R15
            end else if (split_eff) begin
               o_wrl_n = ~(i_word | ~i_a0); // R15
               o_wrh_n = ~(i_word | i_a0);
            end else begin
               o_wrl_n = 1'b0;
            end
         end
         if (split_eff && !(i_strobe_on && i_write)) begin
            o_wrh_n = 1'b1;
         end
      end
   end
endmodule

//--- ebi_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the external bus interface.
// Assumes: Included by bare name; definitions only.
// Notes: Byte addresses on the plain register port.
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH
`define EBI_ADDR_W 8
`define EBI_OFF_MODE_A 8'h04
`define EBI_OFF_MODE_B 8'h05
`define EBI_OFF_CS_CTRL 8'h08
`define EBI_OFF_WAIT_CNT 8'h1b
`define EBI_OFF_STATUS 8'h20
`define EBI_RST_MODE_A 8'h00
`define EBI_RST_MODE_B 8'h00
`define EBI_RST_CS_CTRL 8'h01
`define EBI_RST_WAIT_CNT 8'h00
`define EBI_B_PM_LO 0
`define EBI_B_PM_HI 1
`define EBI_B_STROBE 2
`define EBI_B_MUX_LO 4
`define EBI_B_MUX_HI 5
`define EBI_B_UPPER 6
`define EBI_B_BCLK_DIS 7
`define EBI_B_MID 1
`define EBI_B_NOWAIT0 4
`define EBI_CLK_MHZ 100
`define EBI_CLK_PERIOD_NS 10
`endif

//--- ebi_pkg.sv
// Purpose: Types shared by the external bus interface files.
// Assumes: Offsets and counts live in ebi_map.svh.
// Notes: Nothing here is imported; users write ebi_pkg::name.
package ebi_pkg;
   typedef enum logic [1:0] {
      EBI_PM_SINGLE = 2'h0,
      EBI_PM_EXPAND = 2'h1,
      EBI_PM_FORBID = 2'h2,
      EBI_PM_MICRO = 2'h3
   } ebi_pmode_type;

   typedef enum logic [5:0] {
      EBI_ST_IDLE = 6'h01,
      EBI_ST_ADDR = 6'h02,
      EBI_ST_SWAIT = 6'h04,
      EBI_ST_LAST = 6'h08,
      EBI_ST_RDY = 6'h10,
      EBI_ST_END = 6'h20
   } ebi_state_type;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [1:0] area;
      logic write;
      logic word;
   } ebi_req_type;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data_o;
      logic [15:0] data_oe;
      logic [3:0] cs_n;
      logic rd_n;
      logic wrl_n;
      logic wrh_n;
      logic ale;
   } ebi_pins_type;
endpackage

//--- ebi_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Input is asynchronous to i_core_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module ebi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = i_async;
      sync_d = meta_q;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;
endmodule
